// ### common/can_fc_pkg.sv
// constants, encodings and carrier types for the can error confinement block
package can_fc_pkg;

    // register byte offsets on the apb side
    localparam logic [11:0] INTF_OFFSET   = 12'h000;   // interrupt_flag_register
    localparam logic [11:0] FCOUNT_OFFSET = 12'h004;   // fault_count_register

    // field positions in interrupt_flag_register
    localparam int TXFREE_LSB  = 2;    // tx_buffer_free_flag, one bit per buffer
    localparam int ERRIRQ_BIT  = 5;    // error_irq_flag
    localparam int ANYWARN_BIT = 8;    // any_warning_flag
    localparam int TXWARN_BIT  = 10;   // tx_warning_flag
    localparam int TXPASS_BIT  = 12;   // tx_passive_flag
    localparam int TXBOFF_BIT  = 13;   // tx_busoff_flag
    localparam int RXOVF_LSB   = 14;   // rx_overflow_flag, two bits

    // field positions in fault_count_register
    localparam int RXCNT_LSB = 0;      // rx_fault_count
    localparam int TXCNT_LSB = 16;     // tx_fault_count

    // error counter width and thresholds
    localparam int          CNT_W        = 9;
    localparam logic [8:0]  CNT_RESET    = 9'h000;
    localparam logic [8:0]  CNT_MAX      = 9'h1ff;
    localparam logic [8:0]  ERR_STEP     = 9'h008;
    localparam logic [8:0]  WARN_LIMIT   = 9'h060;   // 96
    localparam logic [8:0]  PASS_LIMIT   = 9'h080;   // 128
    localparam logic [8:0]  BOFF_LIMIT   = 9'h100;   // 256

    // dominant run limits after an error flag
    localparam logic [3:0]  RUN_ACTIVE   = 4'he;     // 14th dominant bit
    localparam logic [3:0]  RUN_PASSIVE  = 4'h8;     // 8th dominant bit
    localparam logic [3:0]  RUN_STEP     = 4'h8;     // every 8 further bits

    // bus-off recovery and end-of-frame counts
    localparam logic [3:0]  IDLE_RUN_BITS = 4'hb;    // 11 recessive bits
    localparam logic [7:0]  RECOVER_SEQS  = 8'h80;   // 128 sequences
    localparam logic [2:0]  EOF_BITS      = 3'h7;

    // value after reset of register bits
    localparam logic [31:0] REG_RESET = 32'h0000_0000;

    // frame field the protocol engine is in
    typedef enum logic [3:0] {
        F_IDLE      = 4'b0000,
        F_ARB       = 4'b0001,
        F_CTRL_DATA = 4'b0010,
        F_CRC       = 4'b0011,
        F_CRC_DEL   = 4'b0100,
        F_ACK_SLOT  = 4'b0101,
        F_ACK_DEL   = 4'b0110,
        F_EOF       = 4'b0111,
        F_IFS       = 4'b1000,
        F_ERR_FLAG  = 4'b1001,
        F_POST_FLAG = 4'b1010
    } field_t;

    // fault confinement state
    typedef enum logic [1:0] {
        ST_ACTIVE  = 2'b00,
        ST_PASSIVE = 2'b01,
        ST_BUSOFF  = 2'b10
    } conf_state_t;

    // position of the current bit as told by the protocol engine
    typedef struct packed {
        logic   txing;        // node is transmitter of this frame
        logic   rxing;        // node is receiver of this frame
        field_t field;        // field of the current bit
        logic   tx_bit;       // level driven, 1 = recessive
        logic   stuff_bit;    // current bit is a stuff bit
        logic   before_rtr;   // bit lies ahead of the remote request bit
    } frame_pos_t;

    // receive counter events from the receive checker
    typedef struct packed {
        logic inc1;
        logic inc8;
        logic dec;
    } rx_evt_t;

endpackage

// ### src/can_error_confinement.sv
// transmit error detection and fault confinement with apb register access
//
// Summary of operation
// RL1 - recessive ack slot unseen: ack error, retry
// RL2 - dominant in delimiters/eof/ifs: form error flag
// RL3 - drove dominant, saw recessive: bit error
// RL4 - recessive overwritten in arbitration/ack: no error
// RL5 - error flag sent adds 8 to tx count
// RL6 - passive ack error leaves tx count alone
// RL7 - arbitration stuff error leaves tx count alone
// RL8 - bit error in active flag adds 8
// RL9 - dominant run after flag adds 8 repeatedly
// RL10 - successful frame decrements tx count by 1, not below 0
// RL11 - free transmit buffer sets its own flag
// RL12 - warning flag at 96, irq on rise
// RL13 - passive flag above 127, irq on rise
// RL14 - bus-off flag above 255, not software clearable
// RL15 - clearing error irq leaves status flags
// RL16 - active/passive error flags; bus-off stays silent
// RL17 - passive when either count reaches 128
// RL18 - bus-off until 128 runs of 11 recessive
// RL19 - any-warning flag while either count >= 96
// RL20 - both counts readable through one register
// RL21 - overflow flags block clearing error irq
// RL22 - error frame, abandon, retransmit soonest
// RL23 - failed buffer gets fault flag, stays pending
// RL24 - reset clears counts, flags; error active
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
module can_error_confinement
    import can_fc_pkg::*;
#(
    parameter int unsigned NUM_TX_BUF = 3
) (
    // clock and reset
    input  wire logic                  sys_clk_in,
    input  wire logic                  rstn_in,
    // apb slave
    input  wire logic                  psel_in,
    input  wire logic                  penable_in,
    input  wire logic                  pwrite_in,
    input  wire logic [11:0]           paddr_in,
    input  wire logic [31:0]           pwdata_in,
    output logic      [31:0]           prdata_out,
    output logic                       pready_out,
    output logic                       pslverr_out,
    // bus pin and protocol engine
    input  wire logic                  can_rx_in,
    input  wire logic                  bit_sample_in,
    input  wire frame_pos_t            frame_pos_in,
    input  wire rx_evt_t               rx_evt_in,
    // transmit buffers and receive overflow
    input  wire logic [NUM_TX_BUF-1:0] tx_request_bit_in,
    input  wire logic [1:0]            tx_buf_sel_in,
    input  wire logic [1:0]            rx_overflow_set_in,
    // to protocol engine and system
    output logic                       err_flag_req_out,
    output logic                       err_flag_recessive_out,
    output logic                       retx_req_out,
    output logic                       bus_off_out,
    output logic [NUM_TX_BUF-1:0]      tx_fault_flag_out,
    output logic                       error_irq_out,
    output logic                       tx_irq_out
);

    // saturating add of one error step
    function automatic logic [CNT_W-1:0] add_step(input logic [CNT_W-1:0] v);
        logic [CNT_W:0] s;
        s = {1'b0, v} + {1'b0, ERR_STEP};
        add_step = s[CNT_W] ? CNT_MAX : s[CNT_W-1:0];
    endfunction

    // pin synchroniser and sampled level
    logic rx_s1_q;                          // first stage, read by rx_s2_q only
    logic rx_s2_q;                          // synchronised bus level
    wire  rx_dom = ~rx_s2_q;                // dominant is low

    // counters and state
    logic [CNT_W-1:0]     tec_q, tec_d;     // tx_fault_count
    logic [CNT_W-1:0]     rec_q, rec_d;     // rx_fault_count
    conf_state_t          state_q, state_d;
    logic [3:0]           run_q, run_d;     // dominant run after a flag
    logic                 flag_passive_q;   // last flag was passive
    logic [3:0]           idle_run_q;       // recessive run while bus-off
    logic [7:0]           seq_q;            // completed recovery runs
    logic [2:0]           eof_cnt_q;        // end-of-frame bits seen
    logic                 ack_ok_q;         // dominant ack seen this frame
    logic                 err_seen_q;       // any error this frame

    // flags
    logic                  warn_q, pass_q, boff_q, anywarn_q;
    logic                  errirq_q;        // error_irq_flag
    logic [1:0]            ovf_q;           // rx_overflow_flag
    logic [NUM_TX_BUF-1:0] free_q;          // tx_buffer_free_flag
    logic [NUM_TX_BUF-1:0] fault_q;         // tx_fault_flag

    // output flops
    logic        err_req_q, retx_q;
    logic [31:0] prdata_q;
    logic        pready_q, pslverr_q;

    // checks are made only on transmitted bits at the sample point
    wire field_t fld    = frame_pos_in.field;
    wire logic   tx_chk = bit_sample_in & frame_pos_in.txing & (state_q != ST_BUSOFF);
    wire logic   in_data = (fld == F_ARB) | (fld == F_CTRL_DATA) | (fld == F_CRC);
    wire logic   in_fixed = (fld == F_CRC_DEL) | (fld == F_ACK_DEL) | (fld == F_EOF)
                            | (fld == F_IFS);

    // recessive acknowledge slot not overwritten
    wire logic ack_err   = tx_chk & (fld == F_ACK_SLOT) & ~rx_dom;                  // RL1
    // dominant where the frame format demands recessive
    wire logic form_err  = tx_chk & in_fixed & rx_dom;                             // RL2
    // dominant driven but recessive read back
    wire logic bit_err_d = tx_chk & in_data & ~frame_pos_in.tx_bit & ~rx_dom;      // RL3
    // recessive overwritten counts only outside arbitration and ack slot
    wire logic bit_err_r = tx_chk & frame_pos_in.tx_bit & rx_dom
                           & ((fld == F_CTRL_DATA) | (fld == F_CRC));              // RL4
    // stuff bit ahead of remote request overwritten in arbitration
    wire logic stuff_arb = tx_chk & (fld == F_ARB) & frame_pos_in.stuff_bit
                           & frame_pos_in.before_rtr & frame_pos_in.tx_bit & rx_dom;
    // bit error inside our own active flag
    wire logic flag_err  = tx_chk & (fld == F_ERR_FLAG) & ~flag_passive_q & ~rx_dom;

    wire logic frame_err = form_err | bit_err_d | bit_err_r | stuff_arb;

    // dominant run after the flag: first limit depends on flag kind
    wire logic [3:0] run_lim = flag_passive_q ? RUN_PASSIVE : RUN_ACTIVE;
    wire logic run_hit = bit_sample_in & (fld == F_POST_FLAG) & rx_dom
                         & ((run_q + 4'h1) == run_lim);                            // RL9

    // tx and rx counter steps
    wire logic tec_add = (frame_err & ~stuff_arb)                                   // RL5 RL7
                         | (ack_err & (state_q == ST_ACTIVE))                       // RL6
                         | flag_err                                                 // RL8
                         | (run_hit & frame_pos_in.txing);                          // RL9
    wire logic rec_add = run_hit & ~frame_pos_in.txing;                             // RL9

    // last recessive eof bit of a clean, acknowledged frame
    wire logic tx_ok = tx_chk & (fld == F_EOF) & ~rx_dom & (eof_cnt_q == EOF_BITS - 3'h1)
                       & ack_ok_q & ~err_seen_q;                                    // RL10

    // bus-off recovery progress
    wire logic idle_run_done = (state_q == ST_BUSOFF) & bit_sample_in & ~rx_dom
                               & ((idle_run_q + 4'h1) == IDLE_RUN_BITS);
    wire logic recovered = idle_run_done & ((seq_q + 8'h01) == RECOVER_SEQS);       // RL18

    // apb decode
    wire logic acc_done = psel_in & penable_in & pready_q;
    wire logic hit_intf = (paddr_in == INTF_OFFSET);
    wire logic hit_cnt  = (paddr_in == FCOUNT_OFFSET);
    wire logic wr_intf  = acc_done & pwrite_in & hit_intf;
    wire logic [1:0] ovf_clr  = wr_intf ? pwdata_in[RXOVF_LSB+1:RXOVF_LSB] : 2'b00;
    // error irq only clears once both overflow flags are already clear
    wire logic errirq_clr = wr_intf & pwdata_in[ERRIRQ_BIT] & (ovf_q == 2'b00);    // RL21 RL15

    // next flag levels from next counter values
    wire logic warn_d    = (tec_d >= WARN_LIMIT);                                   // RL12
    wire logic pass_d    = (tec_d >= PASS_LIMIT);                                   // RL13
    wire logic boff_d    = (state_d == ST_BUSOFF);                                  // RL14
    wire logic anywarn_d = (tec_d >= WARN_LIMIT) | (rec_d >= WARN_LIMIT);           // RL19
    wire logic errirq_set = (warn_d & ~warn_q) | (pass_d & ~pass_q) | (boff_d & ~boff_q)
                            | (|rx_overflow_set_in);

    // register read words
    wire logic [31:0] intf_word = REG_RESET
        | (32'(free_q) << TXFREE_LSB)
        | (32'(errirq_q) << ERRIRQ_BIT)
        | (32'(anywarn_q) << ANYWARN_BIT)
        | (32'(warn_q) << TXWARN_BIT)
        | (32'(pass_q) << TXPASS_BIT)
        | (32'(boff_q) << TXBOFF_BIT)
        | (32'(ovf_q) << RXOVF_LSB);
    wire logic [31:0] cnt_word = REG_RESET
        | (32'(rec_q) << RXCNT_LSB)
        | (32'(tec_q) << TXCNT_LSB); // RL20
    wire logic [31:0] rd_word = hit_intf ? intf_word : (hit_cnt ? cnt_word : REG_RESET);

    // transmit counter next value
    always_comb begin
        tec_d = tec_q;
        if (recovered) begin
            tec_d = CNT_RESET;                                                      // RL18
        end else if (state_q == ST_BUSOFF) begin
            tec_d = tec_q;                                                          // RL16
        end else if (tec_add) begin
            tec_d = add_step(tec_q);
        end else if (tx_ok && (tec_q != CNT_RESET)) begin
            tec_d = tec_q - 9'h001;                                                 // RL10
        end
    end

    // receive counter next value, fed by the receive checker
    always_comb begin
        rec_d = rec_q;
        if (recovered) begin
            rec_d = CNT_RESET;
        end else if (state_q == ST_BUSOFF) begin
            rec_d = rec_q;
        end else if (rec_add || rx_evt_in.inc8) begin
            rec_d = add_step(rec_q);
        end else if (rx_evt_in.inc1 && (rec_q != CNT_MAX)) begin
            rec_d = rec_q + 9'h001;
        end else if (rx_evt_in.dec && (rec_q != CNT_RESET)) begin
            rec_d = rec_q - 9'h001;
        end
    end

    // confinement state from counters; bus-off holds until recovery
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_BUSOFF: begin
                if (recovered) begin
                    state_d = ST_ACTIVE;                                            // RL18
                end
            end
            ST_ACTIVE, ST_PASSIVE: begin
                if (tec_d >= BOFF_LIMIT) begin
                    state_d = ST_BUSOFF;                                            // RL18
                end else if ((tec_d >= PASS_LIMIT) || (rec_d >= PASS_LIMIT)) begin
                    state_d = ST_PASSIVE;                                           // RL17
                end else begin
                    state_d = ST_ACTIVE;                                            // RL17
                end
            end
            default: begin
                state_d = ST_BUSOFF;
            end
        endcase
    end

    // dominant run counter after an error flag
    always_comb begin
        run_d = run_q;
        if (fld != F_POST_FLAG) begin
            run_d = 4'h0;
        end else if (bit_sample_in && !rx_dom) begin
            run_d = 4'h0;
        end else if (run_hit) begin
            run_d = run_lim - RUN_STEP;                                             // RL9
        end else if (bit_sample_in) begin
            run_d = run_q + 4'h1;
        end
    end

    // pin synchroniser
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
        end else begin
            rx_s1_q <= can_rx_in;
            rx_s2_q <= rx_s1_q;
        end
    end

    // counters and confinement state
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tec_q   <= CNT_RESET; // RL24
            rec_q   <= CNT_RESET; // RL24
            state_q <= ST_ACTIVE; // RL24
            run_q   <= 4'h0;
        end else begin
            tec_q   <= tec_d;
            rec_q   <= rec_d;
            state_q <= state_d;
            run_q   <= run_d;
        end
    end

    // per-frame tracking and flag kind
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            flag_passive_q <= 1'b0;
            eof_cnt_q      <= 3'h0;
            ack_ok_q       <= 1'b0;
            err_seen_q     <= 1'b0;
        end else begin
            // flag kind is fixed when the flag starts
            if (fld != F_ERR_FLAG && fld != F_POST_FLAG) begin
                flag_passive_q <= (state_q != ST_ACTIVE);
            end
            // eof bit count
            if (fld != F_EOF) begin
                eof_cnt_q <= 3'h0;
            end else if (bit_sample_in) begin
                eof_cnt_q <= eof_cnt_q + 3'h1;
            end
            // frame bookkeeping restarts at idle
            if (fld == F_IDLE) begin
                ack_ok_q   <= 1'b0;
                err_seen_q <= 1'b0;
            end else begin
                if (tx_chk && fld == F_ACK_SLOT && rx_dom) begin
                    ack_ok_q <= 1'b1;
                end
                if (frame_err || ack_err) begin
                    err_seen_q <= 1'b1;
                end
            end
        end
    end

    // bus-off recovery counting
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            idle_run_q <= 4'h0;
            seq_q      <= 8'h00;
        end else if (state_q != ST_BUSOFF) begin
            idle_run_q <= 4'h0;
            seq_q      <= 8'h00;
        end else if (bit_sample_in) begin
            // a dominant bit restarts the current run only
            if (rx_dom || idle_run_done) begin
                idle_run_q <= 4'h0;
            end else begin
                idle_run_q <= idle_run_q + 4'h1;
            end
            if (idle_run_done) begin
                seq_q <= seq_q + 8'h01;                                             // RL18
            end
        end
    end

    // status and interrupt flags
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            warn_q    <= 1'b0; // RL24
            pass_q    <= 1'b0;
            boff_q    <= 1'b0;
            anywarn_q <= 1'b0;
            errirq_q  <= 1'b0;
            ovf_q     <= 2'b00;
        end else begin
            // status flags follow the counters, never software
            warn_q    <= warn_d;    // RL12
            pass_q    <= pass_d;    // RL13
            boff_q    <= boff_d;    // RL14
            anywarn_q <= anywarn_d; // RL19
            // set wins over a clear in the same cycle
            errirq_q  <= errirq_set | (errirq_q & ~errirq_clr);                    // RL15
            ovf_q     <= rx_overflow_set_in | (ovf_q & ~ovf_clr);
        end
    end

    // transmit buffer flags
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            free_q  <= '0;
            fault_q <= '0;
        end else begin
            // free while not scheduled
            free_q <= ~tx_request_bit_in;                                           // RL11
            for (int i = 0; i < NUM_TX_BUF; i++) begin
                if ((frame_err || ack_err) && (tx_buf_sel_in == i[1:0])) begin
                    fault_q[i] <= 1'b1;                                             // RL23
                end else if (free_q[i] && tx_request_bit_in[i]) begin
                    // a new request clears the old fault
                    fault_q[i] <= 1'b0;
                end
            end
        end
    end

    // requests to the protocol engine
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            err_req_q <= 1'b0;
            retx_q    <= 1'b0;
        end else begin
            // ack errors retry without an error frame
            err_req_q <= frame_err;                                                 // RL2 RL22
            retx_q    <= frame_err | ack_err;                                       // RL1 RL22
        end
    end

    // apb slave: no wait state, ready with data in the first access cycle
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= REG_RESET;
        end else begin
            pready_q  <= psel_in & ~penable_in;
            if (psel_in && !penable_in) begin
                pslverr_q <= ~(hit_intf | hit_cnt);
                prdata_q  <= pwrite_in ? REG_RESET : rd_word;
            end else if (acc_done) begin
                pslverr_q <= 1'b0;
                prdata_q  <= REG_RESET;
            end
        end
    end

    // outputs
    assign prdata_out             = prdata_q;
    assign pready_out             = pready_q;
    assign pslverr_out            = pslverr_q;
    assign err_flag_req_out       = err_req_q;
    assign err_flag_recessive_out = flag_passive_q;                                 // RL16
    assign retx_req_out           = retx_q;
    assign bus_off_out            = boff_q;                                         // RL16
    assign tx_fault_flag_out      = fault_q;
    assign error_irq_out          = errirq_q;
    assign tx_irq_out             = |free_q;                                        // RL11

endmodule

// ### verification/can_fc_assertions.sv
// port checker for the error confinement block, bound after the module
module can_fc_assertions
    import can_fc_pkg::*;
#(parameter int unsigned NUM_TX_BUF = 3) (
    input wire logic sys_clk_in, rstn_in, psel_in, penable_in, pready_out, pslverr_out,
    input wire logic can_rx_in, bit_sample_in, err_flag_req_out, retx_req_out, bus_off_out,
    input wire logic error_irq_out, tx_irq_out,
    input wire logic [11:0] paddr_in,
    input wire logic [NUM_TX_BUF-1:0] tx_request_bit_in,
    input wire frame_pos_t frame_pos_in
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);
    // a sampled bit of a frame we transmit while on the bus
    wire logic tx_s = bit_sample_in && frame_pos_in.txing && !bus_off_out;
    sequence s_setup; psel_in && !penable_in; endsequence
    a_bit_error: assert property (tx_s && frame_pos_in.field == F_CTRL_DATA
        && !frame_pos_in.tx_bit && $past(can_rx_in, 2) |=> err_flag_req_out && retx_req_out)
        else $error("bit error not flagged");
    a_arb_quiet: assert property (tx_s && frame_pos_in.field inside {F_ARB, F_ACK_SLOT}
        && frame_pos_in.tx_bit && !$past(can_rx_in, 2) |=> !err_flag_req_out)
        else $error("flag on overwritten bit");
    a_ack_retry: assert property (tx_s && frame_pos_in.field == F_ACK_SLOT
        && $past(can_rx_in, 2) |=> retx_req_out && !err_flag_req_out)
        else $error("ack error handled wrongly");
    a_form_error: assert property (tx_s && !$past(can_rx_in, 2)
        && frame_pos_in.field inside {F_CRC_DEL, F_ACK_DEL, F_EOF, F_IFS} |=> err_flag_req_out)
        else $error("form error not flagged");
    a_off_silent: assert property (bus_off_out && $past(bus_off_out, 2)
        |-> !err_flag_req_out && !retx_req_out) else $error("activity while bus off");
    a_busoff_irq: assert property ($rose(bus_off_out) |-> ##[0:2] error_irq_out)
        else $error("no error irq on bus off");
    a_apb_answer: assert property (s_setup |=> pready_out ##1 !pready_out)
        else $error("apb answer timing wrong");
    a_bad_address: assert property (pready_out |-> pslverr_out ==
        (paddr_in != INTF_OFFSET && paddr_in != FCOUNT_OFFSET)) else $error("slverr wrong");
    a_free_irq: assert property (($stable(tx_request_bit_in))[*2]
        |-> tx_irq_out == !(&tx_request_bit_in)) else $error("tx irq wrong");
    a_reset_quiet: assert property ($rose(rstn_in) |-> !error_irq_out && !bus_off_out)
        else $error("reset not clean");
endmodule
bind can_error_confinement can_fc_assertions #(.NUM_TX_BUF(NUM_TX_BUF)) i_chk (.*);

// ### verification/can_bus_nodes.sv
// other nodes on the bus: they acknowledge and may disturb our bits
module can_bus_nodes
    import can_fc_pkg::*;
(
    input  wire frame_pos_t frame_pos_in,
    input  wire logic       ack_en_in,
    input  wire logic       fault_en_in,
    output logic            bus_level_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // wired-and bus, a disturbance inverts the bit we drive
    assign bus_level_out = fault_en_in ? !frame_pos_in.tx_bit
        : frame_pos_in.tx_bit && !(ack_en_in && frame_pos_in.field == F_ACK_SLOT);
endmodule

// ### verification/test_can_error_confinement.sv
// directed bench for the error confinement block
module test_can_error_confinement;
    timeunit 1ns;
    timeprecision 1ps;
    import can_fc_pkg::*;
    logic sys_clk_in = 0, rstn_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0;
    logic bit_sample_in = 0, ack_en = 1, fault_en = 0, can_rx_in, pready_out, pslverr_out;
    logic err_flag_req_out, err_flag_recessive_out, retx_req_out, bus_off_out;
    logic error_irq_out, tx_irq_out;
    logic [11:0] paddr_in = 0;
    logic [31:0] pwdata_in = 0, prdata_out, rd;
    logic [2:0]  tx_request_bit_in = 3'h7, tx_fault_flag_out;
    logic [1:0]  tx_buf_sel_in = 2'h2, rx_overflow_set_in = 0;
    frame_pos_t  frame_pos_in = '0;
    rx_evt_t     rx_evt_in = '0;
    int          n_errors = 0, checks_done = 0;
    always #10 sys_clk_in = ~sys_clk_in;
    can_error_confinement i_dut (.*);
    can_bus_nodes i_nodes (.frame_pos_in(frame_pos_in), .ack_en_in(ack_en),
        .fault_en_in(fault_en), .bus_level_out(can_rx_in));
    task chk(input logic [31:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk_in) {psel_in, pwrite_in, paddr_in, pwdata_in} <= {1'b1, w, a, d};
        @(posedge sys_clk_in) penable_in <= 1;
        do @(posedge sys_clk_in); while (pready_out !== 1'b1);
        rd = prdata_out;
        {psel_in, penable_in} <= 2'b00;
    endtask
    task rchk(input logic [11:0] a, input logic [31:0] e);
        apb(0, a, 0);
        chk(rd, e);
    endtask
    task bit_s(input field_t f, input logic lvl);
        @(posedge sys_clk_in) frame_pos_in <= '{1'b1, 1'b0, f, lvl, 1'b0, 1'b0};
        repeat (3) @(posedge sys_clk_in);
        bit_sample_in <= 1;
        @(posedge sys_clk_in) bit_sample_in <= 0;
        repeat (2) @(posedge sys_clk_in);
    endtask
    task report_and_stop;
        $display("checks %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        #400_000;
        n_errors++;
        report_and_stop;
    end
    initial begin
        repeat (4) @(posedge sys_clk_in);
        rstn_in <= 1;
        rchk(FCOUNT_OFFSET, 32'h0000_0000);
        rchk(12'h008, 32'h0000_0000);
        tx_request_bit_in <= 3'h5;
        rchk(INTF_OFFSET, 32'h0000_0008);
        tx_request_bit_in <= 3'h7;
        $display("reset test done");
        fault_en <= 1;
        for (int i = 0; i < 12; i++) bit_s(i[0] ? F_ERR_FLAG : F_CTRL_DATA, 0);
        chk({29'h0, tx_fault_flag_out}, 32'h0000_0004);
        bit_s(F_ARB, 1);
        rchk(FCOUNT_OFFSET, 32'h0060_0000);
        rchk(INTF_OFFSET, 32'h0000_0520);
        apb(1, INTF_OFFSET, 32'h0000_0020);
        rchk(INTF_OFFSET, 32'h0000_0500);
        @(posedge sys_clk_in) rx_overflow_set_in <= 2'h1;
        @(posedge sys_clk_in) rx_overflow_set_in <= 2'h0;
        apb(1, INTF_OFFSET, 32'h0000_4020);
        rchk(INTF_OFFSET, 32'h0000_0520);
        apb(1, INTF_OFFSET, 32'h0000_0020);
        rchk(INTF_OFFSET, 32'h0000_0500);
        $display("warning test done");
        {ack_en, fault_en} <= 2'b00;
        bit_s(F_ACK_SLOT, 1);
        fault_en <= 1;
        bit_s(F_CRC_DEL, 1);
        repeat (2) bit_s(F_CTRL_DATA, 0);
        rchk(INTF_OFFSET, 32'h0000_1520);
        fault_en <= 0;
        bit_s(F_ACK_SLOT, 1);
        ack_en <= 1;
        bit_s(F_IDLE, 1);
        bit_s(F_ACK_SLOT, 1);
        repeat (7) bit_s(F_EOF, 1);
        rchk(FCOUNT_OFFSET, 32'h007f_0000);
        rchk(INTF_OFFSET, 32'h0000_0520);
        $display("passive test done");
        fault_en <= 1;
        repeat (17) bit_s(F_CTRL_DATA, 0);
        rchk(INTF_OFFSET, 32'h0000_3520);
        apb(1, INTF_OFFSET, 32'h0000_2020);
        rchk(INTF_OFFSET, 32'h0000_3500);
        bit_s(F_CTRL_DATA, 0);
        fault_en <= 0;
        repeat (1406) bit_s(F_IDLE, 1);
        chk({31'h0, bus_off_out}, 32'h0000_0001);
        bit_s(F_IDLE, 1);
        chk({31'h0, bus_off_out}, 32'h0000_0000);
        rchk(FCOUNT_OFFSET, 32'h0000_0000);
        $display("bus off test done");
        report_and_stop;
    end
endmodule
